// File: design/tvpu_input_sync.sv
// Three-stage synchroniser for pin inputs, change taken when stages two and three agree
`timescale 1ns/1ps
`include "tvpu_regs.svh"
module tvpu_input_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Pin side and clean side
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  // Per-bit stages and filtered output
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [`TVPU_SYNC_STAGES-1:0] stage_reg;
    logic                         out_reg;
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        stage_reg <= '0;
        out_reg   <= 1'b0;
      end else begin
        stage_reg <= {stage_reg[`TVPU_SYNC_STAGES-2:0], pinIn[i]};
        if (stage_reg[1] == stage_reg[2]) begin
          out_reg <= stage_reg[2];
        end
      end
    end
    assign syncOut[i] = out_reg;
  end

endmodule : tvpu_input_sync

// File: design/tvpu_priority_pick.sv
// Fixed priority picker: lowest index wins
`timescale 1ns/1ps
module tvpu_priority_pick #(
  parameter int unsigned NUM = 11,
  parameter int unsigned IDXW = 4
) (
  // Requests, index 0 highest
  input  wire logic [NUM-1:0]  req,
  // Winner
  output logic                 any,
  output logic [IDXW-1:0]      idx
);

  logic [NUM:0]   higher;
  logic [NUM-1:0] grant;

  // Grant chain, one stage per source
  assign higher[0] = 1'b0;
  for (genvar i = 0; i < NUM; i++) begin : g_chain
    assign grant[i]    = req[i] & ~higher[i];
    assign higher[i+1] = higher[i] | req[i];
  end

  // Encode the one-hot grant
  always_comb begin
    idx = '0;
    for (int i = 0; i < NUM; i++) begin
      if (grant[i]) begin
        idx = IDXW'(i);
      end
    end
  end

  assign any = higher[NUM];

endmodule : tvpu_priority_pick

// File: design/tvpu_trap_vector_unit.sv
// Trap and interrupt vector selection, priority and resumption counter
`timescale 1ns/1ps
`include "tvpu_regs.svh"
module tvpu_trap_vector_unit
  import tvpu_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // External request pins
  input  wire logic        extRequestLevel0,
  input  wire logic        extRequestLevel2,
  // Same-clock interrupt sources
  input  wire logic        internalRequest,
  input  wire logic        timerEvent,
  input  wire logic        timerClear,
  input  wire logic        traceEvent,
  input  wire logic        traceClear,
  // Pipeline trap pulses (non-regenerable)
  input  wire logic        dataMapMiss,
  input  wire logic        unsupportedPeriphAccess,
  input  wire logic        outOfRange,
  input  wire logic        emulOpValid,
  input  wire logic [7:0]  emulOpcode,
  input  wire logic        emulationTrapInstruction,
  input  wire logic [7:0]  emulationTrapVector,
  // Pipeline trap levels (regenerated)
  input  wire logic        unalignedAccess,
  input  wire logic        instMapMiss,
  input  wire logic        illegalOpcode,
  input  wire logic        protectionViolation,
  // Processor control bits
  input  wire logic        trapOnUnalignedEnable,
  input  wire logic        disableAllExceptions,
  input  wire logic        disableInterrupts,
  input  wire logic [1:0]  interruptMask,
  input  wire logic        supervisorMode,
  input  wire logic [31:0] vectorAreaBase,
  // Program counters
  input  wire logic [31:0] currentPc,
  input  wire logic [31:0] followingPc,
  // Exception handshake
  input  wire logic        exceptTaken,
  output logic             exceptValid,
  output logic [7:0]       exceptVector,
  output logic [31:0]      vectorAddress,
  output logic [31:0]      resumptionProgramCounter,
  output logic             channelUpdateAll,
  output logic             resumeAtCurrent,
  // Pending bits
  output logic             timerPending,
  output logic             traceRequestPending
);

  tvpu_state_t state_reg;
  tvpu_state_t state_next;

  logic [1:0]              extSync;
  logic [TVPU_NUM_SRC-1:0] req;
  logic                    reqAny;
  logic [3:0]              reqIdx;
  logic                    took;
  logic                    emulOk;
  logic                    assertOk;
  logic                    extLineNow;

  // Pin requests into the clock domain
  tvpu_input_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .pinIn   ({extRequestLevel2, extRequestLevel0}),
    .syncOut (extSync)
  );

  // Qualified requests, index is priority order
  always_comb begin
    req                = '0;
    req[SRC_NR_P1]     = state_reg.nrPend & state_reg.nrP1;
    req[SRC_UNALIGNED] = unalignedAccess & trapOnUnalignedEnable;
    req[SRC_NR_P2]     = state_reg.nrPend & ~state_reg.nrP1;
    req[SRC_EXT0]      = extSync[0] & ~disableInterrupts;
    req[SRC_EXT2]      = extSync[1] & ~disableInterrupts
                         & interruptMask[`TVPU_IM_EXT2_BIT];
    req[SRC_INTERNAL]  = internalRequest & ~disableInterrupts
                         & (interruptMask == `TVPU_IM_ALL);
    req[SRC_TIMER]     = state_reg.timerPend;
    req[SRC_TRACE]     = state_reg.tracePend;
    req[SRC_IMISS]     = instMapMiss;
    req[SRC_ILLEGAL]   = illegalOpcode;
    req[SRC_PROTECT]   = protectionViolation;
    if (disableAllExceptions) begin
      req = '0;
    end
  end

  // One winner per cycle
  tvpu_priority_pick #(
    .NUM  (TVPU_NUM_SRC),
    .IDXW (4)
  ) u_pick (
    .req (req),
    .any (reqAny),
    .idx (reqIdx)
  );

  // Decoded trap qualifiers
  assign took     = state_reg.valid & exceptTaken;
  assign emulOk   = emulOpValid && emulOpcode >= `TVPU_EMUL_OP_FIRST
                    && emulOpcode <= `TVPU_EMUL_OP_LAST;
  assign assertOk = emulationTrapInstruction
                    && emulationTrapVector >= `TVPU_VEC_ASSERT_MIN;
  assign extLineNow = (state_reg.src == SRC_EXT0) ? extSync[0] : extSync[1];

  // Next state
  always_comb begin
    state_next = state_reg;
    // Pending timer and trace, set wins over clear
    state_next.timerPend = timerEvent | (state_reg.timerPend & ~(timerClear
                           | (took & state_reg.src == SRC_TIMER)));
    state_next.tracePend = traceEvent | (state_reg.tracePend & ~(traceClear
                           | (took & state_reg.src == SRC_TRACE)));
    if (took && (state_reg.src == SRC_NR_P1 || state_reg.src == SRC_NR_P2)) begin
      state_next.nrPend = 1'b0;
    end
    // Catch a non-regenerable trap; they never coincide
    if (!state_next.nrPend) begin
      if (dataMapMiss) begin
        state_next.nrPend = 1'b1;
        state_next.nrP1   = 1'b1;
        state_next.nrChan = 1'b1;
        state_next.nrVec  = supervisorMode ? `TVPU_VEC_SUPV_DMISS
                                           : `TVPU_VEC_USER_DMISS;
      end else if (unsupportedPeriphAccess) begin
        state_next.nrPend = 1'b1;
        state_next.nrP1   = 1'b1;
        state_next.nrChan = 1'b1;
        state_next.nrVec  = `TVPU_VEC_UNSUP_PERIPH;
      end else if (outOfRange) begin
        state_next.nrPend = 1'b1;
        state_next.nrP1   = 1'b0;
        state_next.nrChan = 1'b0;
        state_next.nrVec  = `TVPU_VEC_OUT_OF_RANGE;
      end else if (emulOk) begin
        state_next.nrPend = 1'b1;
        state_next.nrP1   = 1'b0;
        state_next.nrChan = 1'b0;
        state_next.nrVec  = `TVPU_VEC_EMUL_BASE
                            + (emulOpcode - `TVPU_EMUL_OP_FIRST);
      end else if (assertOk) begin
        state_next.nrPend = 1'b1;
        state_next.nrP1   = 1'b0;
        state_next.nrChan = 1'b0;
        state_next.nrVec  = emulationTrapVector;
      end
    end
    // Presented exception
    if (took) begin
      state_next.valid    = 1'b0;
      state_next.spurious = 1'b0;
    end else if (state_reg.valid && state_reg.spurious) begin
      state_next.valid = 1'b1;
    end else if (state_reg.valid && (state_reg.src == SRC_EXT0
                 || state_reg.src == SRC_EXT2) && !extLineNow) begin
      // Request withdrawn before it was taken
      state_next.spurious = 1'b1;
      state_next.vector   = `TVPU_VEC_ILLEGAL;
      state_next.vecAddr  = {vectorAreaBase[31:`TVPU_VADDR_MSB+1],
                             `TVPU_VEC_ILLEGAL,
                             vectorAreaBase[`TVPU_VADDR_LSB-1:0]};
    end else begin
      state_next.valid   = reqAny;
      state_next.src     = tvpu_src_t'(reqIdx);
      state_next.chanAll = 1'b0;
      state_next.pcCurr  = 1'b0;
      state_next.resumePc = followingPc;
      unique case (tvpu_src_t'(reqIdx))
        SRC_NR_P1, SRC_NR_P2: begin
          state_next.vector  = state_reg.nrVec;
          state_next.chanAll = state_reg.nrChan;
        end
        SRC_UNALIGNED: begin
          state_next.vector  = `TVPU_VEC_UNALIGNED;
          state_next.chanAll = 1'b1;
        end
        SRC_EXT0: state_next.vector = `TVPU_VEC_EXT_LEVEL0;
        SRC_EXT2: state_next.vector = `TVPU_VEC_EXT_LEVEL2;
        SRC_INTERNAL: state_next.vector = `TVPU_VEC_INTERNAL;
        SRC_TIMER: state_next.vector = `TVPU_VEC_TIMER;
        SRC_TRACE: state_next.vector = `TVPU_VEC_TRACE;
        SRC_IMISS: begin
          state_next.vector = supervisorMode ? `TVPU_VEC_SUPV_IMISS
                                             : `TVPU_VEC_USER_IMISS;
          state_next.pcCurr = 1'b1;
        end
        SRC_ILLEGAL: begin
          state_next.vector = `TVPU_VEC_ILLEGAL;
          state_next.pcCurr = 1'b1;
        end
        SRC_PROTECT: begin
          state_next.vector = `TVPU_VEC_PROTECTION;
          state_next.pcCurr = 1'b1;
        end
        default: state_next.vector = `TVPU_VEC_ILLEGAL;
      endcase
      // Async: first instruction not executed; Curr category: faulting one
      if (state_next.pcCurr || (reqIdx >= 4'(SRC_EXT0) && reqIdx <= 4'(SRC_TRACE))) begin
        state_next.resumePc = currentPc;
      end
      state_next.vecAddr = {vectorAreaBase[31:`TVPU_VADDR_MSB+1], state_next.vector,
                            vectorAreaBase[`TVPU_VADDR_LSB-1:0]};
    end
  end

  // State register; reset drops any trap caught meanwhile
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg          <= '0;
      state_reg.vector   <= `TVPU_RST_VECTOR;
      state_reg.vecAddr  <= `TVPU_RST_ADDR;
      state_reg.resumePc <= `TVPU_RST_ADDR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign exceptValid              = state_reg.valid;
  assign exceptVector             = state_reg.vector;
  assign vectorAddress            = state_reg.vecAddr;
  assign resumptionProgramCounter = state_reg.resumePc;
  assign channelUpdateAll         = state_reg.chanAll;
  assign resumeAtCurrent          = state_reg.pcCurr;
  assign timerPending             = state_reg.timerPend;
  assign traceRequestPending      = state_reg.tracePend;

  // Checks
  no_fp_vector_a: assert property (@(posedge mclk) disable iff (!resetn)
    exceptValid |-> exceptVector != `TVPU_VEC_FP_EXCEPTION)
    else $error("vector 22 raised by hardware");

  vec_addr_form_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(exceptValid) |-> vectorAddress[9:2] == exceptVector
      && vectorAddress[31:10] == $past(vectorAreaBase[31:10]))
    else $error("vector address malformed");

  take_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
    exceptValid && exceptTaken |=> !exceptValid)
    else $error("exception still shown after take");

  da_block_a: assert property (@(posedge mclk) disable iff (!resetn)
    disableAllExceptions && !exceptValid |=> !exceptValid)
    else $error("exception raised while all disabled");

  timer_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    timerEvent || (timerPending && !timerClear && !(exceptValid && exceptTaken
      && exceptVector == `TVPU_VEC_TIMER)) |=> timerPending)
    else $error("timer pending lost before taken or cleared");

  timer_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    timerClear && !timerEvent |=> !timerPending)
    else $error("timer pending survived a clear");

  trace_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    traceEvent || (traceRequestPending && !traceClear && !(exceptValid && exceptTaken
      && exceptVector == `TVPU_VEC_TRACE)) |=> traceRequestPending)
    else $error("trace pending lost before taken or cleared");

  trace_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    traceClear && !traceEvent |=> !traceRequestPending)
    else $error("trace pending survived a clear");

  unaligned_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(exceptValid) && exceptVector == `TVPU_VEC_UNALIGNED
      |-> $past(trapOnUnalignedEnable))
    else $error("unaligned trap while disabled");

  imiss_curr_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(exceptValid) && state_reg.src == SRC_IMISS
      |-> resumeAtCurrent && !channelUpdateAll
        && resumptionProgramCounter == $past(currentPc))
    else $error("instruction miss resume wrong");

  dmiss_next_a: assert property (@(posedge mclk) disable iff (!resetn)
    !state_reg.nrPend && !exceptValid && dataMapMiss && !disableAllExceptions
      ##1 !disableAllExceptions && !exceptTaken
      |-> ##1 exceptValid && channelUpdateAll && !resumeAtCurrent)
    else $error("data miss not presented at priority one");

  ext_withdraw_a: assert property (@(posedge mclk) disable iff (!resetn)
    exceptValid && !exceptTaken && exceptVector == `TVPU_VEC_EXT_LEVEL0
      && !extSync[0] |=> exceptValid && exceptVector == `TVPU_VEC_ILLEGAL)
    else $error("withdrawn request not turned to vector 0");

  emul_vec_a: assert property (@(posedge mclk) disable iff (!resetn)
    !state_reg.nrPend && emulOpValid && emulOpcode == `TVPU_EMUL_OP_FIRST
      && !dataMapMiss && !unsupportedPeriphAccess && !outOfRange
      |=> state_reg.nrPend && state_reg.nrVec == `TVPU_VEC_EMUL_BASE)
    else $error("emulated opcode vector wrong");

  ext2_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(exceptValid) && exceptVector == `TVPU_VEC_EXT_LEVEL2
      |-> $past(interruptMask[`TVPU_IM_EXT2_BIT]) && !$past(disableInterrupts))
    else $error("level two request taken while masked");

  internal_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(exceptValid) && exceptVector == `TVPU_VEC_INTERNAL
      |-> $past(interruptMask) == `TVPU_IM_ALL && !$past(disableInterrupts))
    else $error("internal request taken while masked");

  async_resume_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(exceptValid) && exceptVector inside {`TVPU_VEC_TIMER, `TVPU_VEC_TRACE,
      `TVPU_VEC_EXT_LEVEL0, `TVPU_VEC_EXT_LEVEL2, `TVPU_VEC_INTERNAL}
      |-> resumptionProgramCounter == $past(currentPc) && !resumeAtCurrent)
    else $error("async resume address wrong");

endmodule : tvpu_trap_vector_unit

// File: shared/tvpu_pkg.sv
// Types shared by the trap vector unit modules
package tvpu_pkg;

  // Request sources, highest priority first
  typedef enum logic [3:0] {
    SRC_NR_P1     = 4'b0000,
    SRC_UNALIGNED = 4'b0001,
    SRC_NR_P2     = 4'b0010,
    SRC_EXT0      = 4'b0011,
    SRC_EXT2      = 4'b0100,
    SRC_INTERNAL  = 4'b0101,
    SRC_TIMER     = 4'b0110,
    SRC_TRACE     = 4'b0111,
    SRC_IMISS     = 4'b1000,
    SRC_ILLEGAL   = 4'b1001,
    SRC_PROTECT   = 4'b1010
  } tvpu_src_t;

  localparam int unsigned TVPU_NUM_SRC = 11;

  // Whole state of the unit
  typedef struct packed {
    logic        valid;
    tvpu_src_t   src;
    logic [7:0]  vector;
    logic [31:0] vecAddr;
    logic [31:0] resumePc;
    logic        chanAll;
    logic        pcCurr;
    logic        spurious;
    logic        nrPend;
    logic        nrP1;
    logic [7:0]  nrVec;
    logic        nrChan;
    logic        timerPend;
    logic        tracePend;
  } tvpu_state_t;

endpackage : tvpu_pkg

// File: shared/tvpu_regs.svh
// Vector numbers, field positions, reset values and timing counts of the trap vector unit
`ifndef TVPU_REGS_SVH
`define TVPU_REGS_SVH

`define TVPU_VEC_ILLEGAL      8'h00
`define TVPU_VEC_UNALIGNED    8'h01
`define TVPU_VEC_OUT_OF_RANGE 8'h02
`define TVPU_VEC_PROTECTION   8'h05
`define TVPU_VEC_UNSUP_PERIPH 8'h06
`define TVPU_VEC_USER_IMISS   8'h08
`define TVPU_VEC_USER_DMISS   8'h09
`define TVPU_VEC_SUPV_IMISS   8'h0a
`define TVPU_VEC_SUPV_DMISS   8'h0b
`define TVPU_VEC_TIMER        8'h0e
`define TVPU_VEC_TRACE        8'h0f
`define TVPU_VEC_EXT_LEVEL0   8'h10
`define TVPU_VEC_EXT_LEVEL2   8'h12
`define TVPU_VEC_INTERNAL     8'h13
`define TVPU_VEC_FP_EXCEPTION 8'h16
`define TVPU_VEC_EMUL_BASE    8'h18
`define TVPU_EMUL_OP_FIRST    8'hd8
`define TVPU_EMUL_OP_LAST     8'hdd
`define TVPU_VEC_ASSERT_MIN   8'h40
`define TVPU_VADDR_LSB        2
`define TVPU_VADDR_MSB        9
`define TVPU_IM_EXT2_BIT      1
`define TVPU_IM_ALL           2'h3
`define TVPU_RST_VECTOR       8'h00
`define TVPU_RST_ADDR         32'h0000_0000
`define TVPU_SYNC_STAGES      3

`endif

// File: testbench/tb_tvpu_trap_vector_unit.sv
// Self-checking bench of the trap vector unit
`timescale 1ns/1ps
`include "tvpu_regs.svh"
module tb_tvpu_trap_vector_unit;
  logic mclk = 1'b0;
  logic resetn, internalRequest, timerEvent, timerClear, traceEvent, traceClear;
  logic dataMapMiss, unsupportedPeriphAccess, outOfRange, emulOpValid, drop0;
  logic emulationTrapInstruction, unalignedAccess, instMapMiss, illegalOpcode;
  logic protectionViolation, trapOnUnalignedEnable, disableAllExceptions;
  logic disableInterrupts, supervisorMode, exceptTaken, exceptValid;
  logic channelUpdateAll, resumeAtCurrent, timerPending, traceRequestPending;
  logic extRequestLevel0, extRequestLevel2;
  logic [1:0]  interruptMask, raise;
  logic [3:0]  takeDelay;
  logic [7:0]  emulOpcode, emulationTrapVector, exceptVector;
  logic [7:0]  vecs [5];
  logic [31:0] vectorAreaBase, currentPc, followingPc, vectorAddress, resumptionProgramCounter;
  int          seed, numErrors, checkCount, n;

  tvpu_trap_vector_unit uut (.mclk, .resetn, .extRequestLevel0, .extRequestLevel2,
    .internalRequest, .timerEvent, .timerClear, .traceEvent, .traceClear, .dataMapMiss,
    .unsupportedPeriphAccess, .outOfRange, .emulOpValid, .emulOpcode,
    .emulationTrapInstruction, .emulationTrapVector, .unalignedAccess, .instMapMiss,
    .illegalOpcode, .protectionViolation, .trapOnUnalignedEnable, .disableAllExceptions,
    .disableInterrupts, .interruptMask, .supervisorMode, .vectorAreaBase, .currentPc,
    .followingPc, .exceptTaken, .exceptValid, .exceptVector, .vectorAddress,
    .resumptionProgramCounter, .channelUpdateAll, .resumeAtCurrent, .timerPending,
    .traceRequestPending);

  tvpu_far_side far (.mclk, .resetn, .raise, .drop0, .takeDelay, .exceptValid,
    .exceptVector, .extRequestLevel0, .extRequestLevel2, .exceptTaken);

  // Clock, 20 ns period
  always #10 mclk = ~mclk;

  // Hardware never reports the floating-point vector
  always @(negedge mclk) if (exceptValid === 1'b1) chk("noFp", exceptVector === 8'h16, 0);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  function automatic logic [7:0] emul_vec(input logic [7:0] op);
    return `TVPU_VEC_EMUL_BASE + (op - `TVPU_EMUL_OP_FIRST);
  endfunction : emul_vec

  // New random base, counters and take delay
  task automatic shuffle();
    vectorAreaBase = $random(seed);
    currentPc = $random(seed);
    followingPc = currentPc + 32'h4;
    supervisorMode = 1'($random(seed));
    takeDelay = 4'({$random(seed)} % 4);
  endtask : shuffle

  // Chan 2 means the channel flag is not judged
  task automatic expect_exc(input logic [7:0] vec, input logic [31:0] pc,
                            input logic [1:0] chan, input logic cur);
    n = 0;
    while (exceptValid !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    chk("valid", exceptValid, 1);
    chk("vector", exceptVector, vec);
    chk("vaddr", vectorAddress, {vectorAreaBase[31:10], vec, vectorAreaBase[1:0]});
    chk("pc", resumptionProgramCounter, pc);
    if (chan != 2'd2) chk("chan", channelUpdateAll, chan[0]);
    chk("cur", resumeAtCurrent, cur);
  endtask : expect_exc

  task automatic take_it();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (exceptTaken !== 1'b1 && n < 40);
    chk("taken", exceptTaken, 1);
    #1;
  endtask : take_it

  // Take a pin request; handler keeps interrupts off until the dropped pin settles
  task automatic take_ext();
    take_it();
    disableInterrupts = 1'b1;
    repeat (6) tick();
    disableInterrupts = 1'b0;
  endtask : take_ext

  task automatic quiet(input string what);
    repeat (5) tick();
    chk(what, exceptValid, 0);
  endtask : quiet

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    #100000;
    numErrors++;
    give_verdict();
  end

  initial begin
    seed = 23;
    {resetn, internalRequest, timerEvent, timerClear, traceEvent, traceClear, dataMapMiss,
     unsupportedPeriphAccess, outOfRange, emulOpValid, emulationTrapInstruction,
     unalignedAccess, instMapMiss, illegalOpcode, protectionViolation, trapOnUnalignedEnable,
     disableAllExceptions, disableInterrupts, drop0, raise, emulOpcode,
     emulationTrapVector} = '0;
    interruptMask = 2'h3;
    shuffle();
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    // Disable-all, then illegal opcode regenerated behind a data miss
    disableAllExceptions = 1'b1;
    illegalOpcode = 1'b1;
    quiet("disAll");
    disableAllExceptions = 1'b0;
    expect_exc(8'h00, currentPc, 0, 1);
    take_it();
    illegalOpcode = 1'b0;
    dataMapMiss = 1'b1;
    tick();
    dataMapMiss = 1'b0;
    illegalOpcode = 1'b1;
    expect_exc(supervisorMode ? 8'h0b : 8'h09, followingPc, 1, 0);
    take_it();
    expect_exc(8'h00, currentPc, 0, 1);
    take_it();
    expect_exc(8'h00, currentPc, 0, 1);
    take_it();
    illegalOpcode = 1'b0;
    $display("test instruction traps done");
    // Unaligned, protection, inst miss, unsupported address
    shuffle();
    unalignedAccess = 1'b1;
    quiet("noTu");
    trapOnUnalignedEnable = 1'b1;
    expect_exc(8'h01, followingPc, 1, 0);
    take_it();
    unalignedAccess = 1'b0;
    protectionViolation = 1'b1;
    expect_exc(8'h05, currentPc, 0, 1);
    take_it();
    protectionViolation = 1'b0;
    instMapMiss = 1'b1;
    expect_exc(supervisorMode ? 8'h0a : 8'h08, currentPc, 0, 1);
    take_it();
    instMapMiss = 1'b0;
    unsupportedPeriphAccess = 1'b1;
    tick();
    unsupportedPeriphAccess = 1'b0;
    expect_exc(8'h06, followingPc, 1, 0);
    take_it();
    $display("test fault traps done");
    // Emulated opcodes, one past the range
    for (int op = 8'hd8; op <= 8'hde; op++) begin
      emulOpValid = 1'b1;
      emulOpcode = 8'(op);
      tick();
      emulOpValid = 1'b0;
      if (op == 8'hde) quiet("emulOut");
      else begin
        expect_exc(emul_vec(8'(op)), followingPc, 2, 0);
        take_it();
      end
    end
    // Instruction-given vectors
    vecs = '{8'h40, 8'hff, 8'h00, 8'h3f, 8'h16};
    vecs[2] = 8'h41 + 8'({$random(seed)} % 190);
    foreach (vecs[i]) begin
      emulationTrapInstruction = 1'b1;
      emulationTrapVector = vecs[i];
      tick();
      emulationTrapInstruction = 1'b0;
      if (vecs[i] < 8'h40) quiet("lowVec");
      else begin
        expect_exc(vecs[i], followingPc, 2, 0);
        take_it();
      end
    end
    $display("test emulation done");
    // Internal refused by disable-interrupts, timer and trace held
    shuffle();
    interruptMask = 2'h2;
    internalRequest = 1'b1;
    quiet("imMask");
    interruptMask = 2'h3;
    disableInterrupts = 1'b1;
    internalRequest = 1'b1;
    {timerEvent, traceEvent} = 2'h3;
    tick();
    {timerEvent, traceEvent} = 2'h0;
    chk("pend", {timerPending, traceRequestPending}, 2'h3);
    expect_exc(8'h0e, currentPc, 2, 0);
    take_it();
    disableInterrupts = 1'b0;
    expect_exc(8'h13, currentPc, 2, 0);
    take_it();
    internalRequest = 1'b0;
    chk("pend2", {timerPending, traceRequestPending}, 2'h1);
    expect_exc(8'h0f, currentPc, 2, 0);
    take_it();
    // Clear drops a held bit, a set in the same cycle wins
    disableAllExceptions = 1'b1;
    {timerEvent, traceEvent} = 2'h3;
    tick();
    {timerEvent, traceEvent, timerClear, traceClear} = 4'h7;
    tick();
    chk("setWins", {timerPending, traceRequestPending}, 2'h1);
    {timerEvent, traceEvent, timerClear, traceClear} = 4'h1;
    tick();
    chk("clear", {timerPending, traceRequestPending}, 2'h0);
    {timerEvent, traceEvent, timerClear, traceClear} = 4'h0;
    disableAllExceptions = 1'b0;
    quiet("cleared");
    // Both pins, then a withdrawn level 0 request
    raise = 2'h3;
    tick();
    raise = 2'h0;
    expect_exc(8'h10, currentPc, 2, 0);
    take_ext();
    expect_exc(8'h12, currentPc, 2, 0);
    take_ext();
    takeDelay = 4'hf;
    raise = 2'h1;
    tick();
    raise = 2'h0;
    expect_exc(8'h10, currentPc, 2, 0);
    drop0 = 1'b1;
    tick();
    drop0 = 1'b0;
    for (int k = 0; k < 20 && exceptVector !== 8'h00; k++) tick();
    chk("withdraw", exceptVector, 8'h00);
    takeDelay = 4'h0;
    take_it();
    $display("test interrupts done");
    // Trap pulses during reset are lost
    resetn = 1'b0;
    {outOfRange, dataMapMiss} = 2'h3;
    repeat (2) tick();
    {outOfRange, dataMapMiss} = 2'h0;
    resetn = 1'b1;
    quiet("rstLost");
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_tvpu_trap_vector_unit

// File: testbench/tvpu_far_side.sv
// Far-side model: external request sources and the accepting pipeline
`timescale 1ns/1ps
module tvpu_far_side (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Commands from the bench
  input  wire logic [1:0] raise,
  input  wire logic       drop0,
  input  wire logic [3:0] takeDelay,
  // Exception side
  input  wire logic       exceptValid,
  input  wire logic [7:0] exceptVector,
  output logic            extRequestLevel0,
  output logic            extRequestLevel2,
  output logic            exceptTaken
);
  logic [3:0] waitCnt = 4'h0;
  logic       took0;
  logic       took2;

  initial {extRequestLevel0, extRequestLevel2, exceptTaken} = 3'h0;

  // Lines held until taken or, for level 0, dropped; take after a chosen wait
  always @(posedge mclk) begin
    took0 = exceptTaken && exceptVector == 8'h10;
    took2 = exceptTaken && exceptVector == 8'h12;
    #1;
    if (!resetn || took0 || drop0) extRequestLevel0 = 1'b0;
    else if (raise[0]) extRequestLevel0 = 1'b1;
    if (!resetn || took2) extRequestLevel2 = 1'b0;
    else if (raise[1]) extRequestLevel2 = 1'b1;
    if (!exceptValid || exceptTaken) begin
      waitCnt = 4'h0;
      exceptTaken = 1'b0;
    end else if (waitCnt >= takeDelay) exceptTaken = 1'b1;
    else waitCnt = waitCnt + 4'h1;
  end
endmodule : tvpu_far_side
